/* hdl/sdram_command_clock_enable.sv */
`default_nettype none
module sdram_command_clock_enable #(
  parameter int DATA_W = sdram_pkg::DATA_W
) (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic                        cke,
  input  wire logic                        cs_n,
  input  wire logic                        ras_n,
  input  wire logic                        cas_n,
  input  wire logic                        we_n,
  input  wire logic [sdram_pkg::BANK_W-1:0] ba,
  input  wire logic [sdram_pkg::ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0]           dq_in,
  input  wire logic [2:0]                  burst_len,
  input  wire logic                        burst_interleave,
  input  wire logic                        read_latency_three,
  output logic      [DATA_W-1:0]           dq_out,
  output logic                             dq_oe,
  output logic      [sdram_pkg::BANKS-1:0] bank_open,
  output logic                             power_down,
  output logic                             self_refresh,
  output logic      [sdram_pkg::ROW_W-1:0] refresh_row
);
  localparam int BW = sdram_pkg::BANK_W;
  localparam int RW = sdram_pkg::ROW_W;
  localparam int CW = sdram_pkg::COL_W;
  localparam int NB = sdram_pkg::BANKS;
  localparam int TW = sdram_pkg::REFRESH_CNT_W;
  localparam logic [TW-1:0] REF_LAST =
    TW'(sdram_pkg::REFRESH_INTERVAL_CYC - 1);

  logic rst_meta_reg;
  logic rst_n_reg;
  logic cke_meta_reg;
  logic cke_sync_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'h0;
      rst_n_reg    <= 1'h0;
    end else begin
      rst_meta_reg <= 1'h1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // Exit from a low-power mode may arrive at any time
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      cke_meta_reg <= 1'h0;
      cke_sync_reg <= 1'h0;
    end else begin
      cke_meta_reg <= cke;
      cke_sync_reg <= cke_meta_reg;
    end
  end

  storage_if #(.AW(sdram_pkg::MEM_AW), .DW(DATA_W)) store ();

  sdram_storage #(.AW(sdram_pkg::MEM_AW), .DW(DATA_W)) u_storage (
    .clk  (clk),
    .port (store.mem)
  );

  sdram_pkg::power_state_t state_reg, state_next;
  logic              clk_en_reg,   clk_en_next;
  logic [NB-1:0]     open_reg,     open_next;
  logic [RW-1:0]     row_reg [NB];
  logic [RW-1:0]     row_next [NB];
  logic              act_reg,      act_next;
  logic              wr_reg,       wr_next;
  logic              ap_reg,       ap_next;
  logic [BW-1:0]     bank_reg,     bank_next;
  logic [RW-1:0]     brow_reg,     brow_next;
  logic [CW-1:0]     start_reg,    start_next;
  logic [CW-1:0]     cnt_reg,      cnt_next;
  logic [RW-1:0]     ref_row_reg,  ref_row_next;
  logic [TW-1:0]     ref_tmr_reg,  ref_tmr_next;
  logic              rd_v0_reg,    rd_v0_next;
  logic              rd_v1_reg;
  logic [DATA_W-1:0] rd_d1_reg;
  logic [DATA_W-1:0] dq_out_reg;
  logic              dq_oe_reg;

  logic [3:0]    cmd;
  logic          idle;
  logic          cur_act;
  logic          cur_wr;
  logic          cur_ap;
  logic [BW-1:0] cur_bank;
  logic [RW-1:0] cur_row;
  logic [CW-1:0] cur_start;
  logic [CW-1:0] cur_cnt;
  logic [CW-1:0] mask;
  logic [CW-1:0] col;
  logic          last;
  logic          full;
  logic          run;

  always_comb begin
    case (burst_len)
      sdram_pkg::BL_1:    mask = sdram_pkg::MASK_1;
      sdram_pkg::BL_2:    mask = sdram_pkg::MASK_2;
      sdram_pkg::BL_4:    mask = sdram_pkg::MASK_4;
      sdram_pkg::BL_8:    mask = sdram_pkg::MASK_8;
      default:            mask = sdram_pkg::MASK_FULL;
    endcase
    full = (burst_len == sdram_pkg::BL_FULL);
  end

  always_comb begin
    state_next   = state_reg;
    clk_en_next  = clk_en_reg;
    open_next    = open_reg;
    row_next     = row_reg;
    act_next     = act_reg;
    wr_next      = wr_reg;
    ap_next      = ap_reg;
    bank_next    = bank_reg;
    brow_next    = brow_reg;
    start_next   = start_reg;
    cnt_next     = cnt_reg;
    ref_row_next = ref_row_reg;
    ref_tmr_next = ref_tmr_reg;
    rd_v0_next   = rd_v0_reg;
    cur_act      = act_reg;
    cur_wr       = wr_reg;
    cur_ap       = ap_reg;
    cur_bank     = bank_reg;
    cur_row      = brow_reg;
    cur_start    = start_reg;
    cur_cnt      = cnt_reg;
    col          = start_reg;
    last         = 1'h0;
    run          = 1'h0;
    idle         = (open_reg == '0) && !act_reg;
    // Deselected device sees a no-operation
    cmd = cs_n ? sdram_pkg::CMD_NOP : {1'h0, ras_n, cas_n, we_n};
    case (state_reg)
      sdram_pkg::ST_RUN: begin
        clk_en_next = cke;
        if (clk_en_reg) begin
          run        = 1'h1;
          rd_v0_next = 1'h0;
          if (cmd == sdram_pkg::CMD_STOP) begin
            cur_act = 1'h0;
          end
          if ((cmd == sdram_pkg::CMD_READ || cmd == sdram_pkg::CMD_WRITE)
              && open_reg[ba]) begin
            cur_act   = 1'h1;
            cur_wr    = (cmd == sdram_pkg::CMD_WRITE);
            cur_ap    = addr[sdram_pkg::AP_BIT];
            cur_bank  = ba;
            cur_row   = row_reg[ba];
            cur_start = addr[CW-1:0];
            cur_cnt   = '0;
          end
          if (burst_interleave) begin
            col = cur_start ^ (cur_cnt & mask);
          end else begin
            col = (cur_start & ~mask) |
                  (CW'(cur_start + cur_cnt) & mask);
          end
          last       = (cur_cnt == mask) && !full;
          act_next   = cur_act && !last;
          wr_next    = cur_wr;
          ap_next    = cur_ap;
          bank_next  = cur_bank;
          brow_next  = cur_row;
          start_next = cur_start;
          cnt_next   = cur_act ? CW'(cur_cnt + 8'h01) : cur_cnt;
          rd_v0_next = cur_act && !cur_wr;
          if (cur_act && last && cur_ap) begin
            open_next[cur_bank] = 1'h0;
          end
          case (cmd)
            sdram_pkg::CMD_ROWOPEN: begin
              if (!open_reg[ba]) begin
                open_next[ba] = 1'h1;
                row_next[ba]  = addr[RW-1:0];
              end
            end
            sdram_pkg::CMD_PRECHG: begin
              if (addr[sdram_pkg::AP_BIT]) begin
                open_next = '0;
              end else begin
                open_next[ba] = 1'h0;
              end
            end
            sdram_pkg::CMD_REFRESH: begin
              if (idle) begin
                ref_row_next = RW'(ref_row_reg + 12'h001);
              end
            end
            default: begin
            end
          endcase
          // Without idle banks a low enable is only a suspend
          if (!cke && idle) begin
            ref_tmr_next = '0;
            if (cmd == sdram_pkg::CMD_REFRESH) begin
              state_next = sdram_pkg::ST_SELF_REFRESH;
            end else begin
              state_next = sdram_pkg::ST_POWER_DOWN;
            end
          end
        end
      end
      sdram_pkg::ST_POWER_DOWN, sdram_pkg::ST_SELF_REFRESH: begin
        // No command decode here; the enable flag arms the wake-up, so a
        // stale high left in the synchroniser at entry cannot wake it
        clk_en_next = clk_en_reg || !cke_sync_reg;
        rd_v0_next  = 1'h0;
        if (state_reg == sdram_pkg::ST_SELF_REFRESH) begin
          if (ref_tmr_reg == REF_LAST) begin
            ref_tmr_next = '0;
            ref_row_next = RW'(ref_row_reg + 12'h001);
          end else begin
            ref_tmr_next = TW'(ref_tmr_reg + 11'h001);
          end
        end
        if (cke_sync_reg && clk_en_reg) begin
          state_next  = sdram_pkg::ST_RUN;
          clk_en_next = 1'h1;
        end
      end
      default: begin
        state_next = sdram_pkg::ST_RUN;
      end
    endcase
  end

  assign store.en    = run;
  assign store.we    = run && cur_act && cur_wr;
  assign store.addr  = {cur_bank, cur_row, col};
  assign store.wdata = dq_in;

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg   <= sdram_pkg::ST_RUN;
      clk_en_reg  <= 1'h0;
      open_reg    <= '0;
      act_reg     <= 1'h0;
      wr_reg      <= 1'h0;
      ap_reg      <= 1'h0;
      bank_reg    <= '0;
      brow_reg    <= '0;
      start_reg   <= '0;
      cnt_reg     <= '0;
      ref_row_reg <= '0;
      ref_tmr_reg <= '0;
      rd_v0_reg   <= 1'h0;
      for (int i = 0; i < NB; i++) begin
        row_reg[i] <= '0;
      end
    end else begin
      state_reg   <= state_next;
      clk_en_reg  <= clk_en_next;
      open_reg    <= open_next;
      act_reg     <= act_next;
      wr_reg      <= wr_next;
      ap_reg      <= ap_next;
      bank_reg    <= bank_next;
      brow_reg    <= brow_next;
      start_reg   <= start_next;
      cnt_reg     <= cnt_next;
      ref_row_reg <= ref_row_next;
      ref_tmr_reg <= ref_tmr_next;
      rd_v0_reg   <= rd_v0_next;
      row_reg     <= row_next;
    end
  end

  // Read pipeline; stage one only feeds the three-cycle latency
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rd_v1_reg  <= 1'h0;
      rd_d1_reg  <= '0;
      dq_out_reg <= '0;
      dq_oe_reg  <= 1'h0;
    end else if (run) begin
      rd_v1_reg <= rd_v0_reg;
      rd_d1_reg <= store.rdata;
      if (read_latency_three) begin
        dq_out_reg <= rd_d1_reg;
        dq_oe_reg  <= rd_v1_reg;
      end else begin
        dq_out_reg <= store.rdata;
        dq_oe_reg  <= rd_v0_reg;
      end
    end else if (state_reg != sdram_pkg::ST_RUN) begin
      rd_v1_reg <= 1'h0;
      dq_oe_reg <= 1'h0;
    end
  end

  assign dq_out       = dq_out_reg;
  assign dq_oe        = dq_oe_reg;
  assign bank_open    = open_reg;
  assign power_down   = (state_reg == sdram_pkg::ST_POWER_DOWN);
  assign self_refresh = (state_reg == sdram_pkg::ST_SELF_REFRESH);
  assign refresh_row  = ref_row_reg;
endmodule
`default_nettype wire

/* hdl/sdram_pkg.sv */
`default_nettype none
package sdram_pkg;
  localparam int BANK_W   = 2;
  localparam int BANKS    = 4;
  localparam int ROW_W    = 12;
  localparam int COL_W    = 8;
  localparam int ADDR_W   = 12;
  localparam int DATA_W   = 16;
  localparam int MEM_AW   = BANK_W + ROW_W + COL_W;
  localparam int AP_BIT   = 10;

  // Command code is {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MODE    = 4'h0;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_PRECHG  = 4'h2;
  localparam logic [3:0] CMD_ROWOPEN = 4'h3;
  localparam logic [3:0] CMD_WRITE   = 4'h4;
  localparam logic [3:0] CMD_READ    = 4'h5;
  localparam logic [3:0] CMD_STOP    = 4'h6;
  localparam logic [3:0] CMD_NOP     = 4'h7;

  // Burst length select codes
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;

  localparam logic [COL_W-1:0] MASK_1    = 8'h00;
  localparam logic [COL_W-1:0] MASK_2    = 8'h01;
  localparam logic [COL_W-1:0] MASK_4    = 8'h03;
  localparam logic [COL_W-1:0] MASK_8    = 8'h07;
  localparam logic [COL_W-1:0] MASK_FULL = 8'hFF;

  localparam int REFRESH_ROWS      = 4096;
  localparam int REFRESH_WINDOW_MS = 64;
  localparam int CLK_PERIOD_NS     = 10;
  // Longest spacing between refreshes, rounded down
  localparam int REFRESH_INTERVAL_CYC =
    (REFRESH_WINDOW_MS * 1000000) / REFRESH_ROWS / CLK_PERIOD_NS;
  localparam int REFRESH_CNT_W = 11;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_POWER_DOWN,
    ST_SELF_REFRESH
  } power_state_t;
endpackage
`default_nettype wire

/* hdl/storage_if.sv */
`default_nettype none
interface storage_if #(
  parameter int AW = sdram_pkg::MEM_AW,
  parameter int DW = sdram_pkg::DATA_W
);
  logic          en;
  logic          we;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctrl (output en, output we, output addr, output wdata,
                input rdata);
  modport mem  (input en, input we, input addr, input wdata,
                output rdata);
endinterface
`default_nettype wire

/* hdl/sdram_storage.sv */
`default_nettype none
module sdram_storage #(
  parameter int AW = sdram_pkg::MEM_AW,
  parameter int DW = sdram_pkg::DATA_W
) (
  input  wire logic clk,
  storage_if.mem    port
);
  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] rdata_reg;

  // A suspended clock leaves the read register frozen
  always_ff @(posedge clk) begin
    if (port.en) begin
      if (port.we) begin
        mem[port.addr] <= port.wdata;
      end
      rdata_reg <= mem[port.addr];
    end
  end

  assign port.rdata = rdata_reg;
endmodule
`default_nettype wire

/* tb/sdram_ctrl_model.sv */
`default_nettype none
module sdram_ctrl_model (
  output logic        cke,
  output logic        cs_n,
  output logic        ras_n,
  output logic        cas_n,
  output logic        we_n,
  output logic [1:0]  ba,
  output logic [11:0] addr,
  output logic [15:0] dq_in,
  input  wire logic   clk
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = sdram_pkg::CMD_NOP;
    ba = 2'h0;
    addr = 12'h000;
    dq_in = 16'h0000;
  end
  // One command per rising edge, bank and row or column with it
  task automatic cmd(input logic [3:0] c, input logic [1:0] b,
                     input logic [11:0] a);
    @(negedge clk);
    {cs_n, ras_n, cas_n, we_n} = c;
    ba = b;
    addr = a;
  endtask
  // Released lines flip so a stale value is never mistaken for a new one
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk);
      {cs_n, ras_n, cas_n, we_n} = sdram_pkg::CMD_NOP;
      ba = ~ba;
      addr = ~addr;
    end
  endtask
  // Eight words into an opened row, each word names its column
  task automatic write8(input logic [1:0] b);
    for (int i = 0; i < 8; i++) begin
      if (i == 0) cmd(sdram_pkg::CMD_WRITE, b, 12'h000);
      else idle(1);
      dq_in = {6'h29, b, 8'(i)};
    end
  endtask
  // Command and clock enable change together, as for self-refresh entry
  task automatic cmd_cke(input logic [3:0] c, input logic v);
    @(negedge clk);
    {cs_n, ras_n, cas_n, we_n} = c;
    cke = v;
  endtask
  task automatic set_cke(input logic v);
    @(negedge clk);
    cke = v;
  endtask
endmodule
`default_nettype wire

/* tb/sdram_command_clock_enable_sva.sv */
`default_nettype none
module sdram_cce_checker (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [1:0]  ba,
  input wire logic [11:0] addr,
  input wire logic        read_latency_three,
  input wire logic [15:0] dq_out,
  input wire logic        dq_oe,
  input wire logic [3:0]  bank_open,
  input wire logic        power_down,
  input wire logic        self_refresh,
  input wire logic [11:0] refresh_row
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       cke_q;
  logic       run;
  logic [3:0] cmd;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign run = cke_q && !power_down && !self_refresh;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) cke_q <= 1'b0;
    else cke_q <= cke;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_ROW_OPEN: assert property (
    |(bank_open & ~$past(bank_open)) |-> $past(cmd) == sdram_pkg::CMD_ROWOPEN
      && (bank_open ^ $past(bank_open)) == (4'h1 << $past(ba)))
    else $error("bank opened without a row-open command");
  AST_CLOSE_ALL: assert property (
    run && cmd == sdram_pkg::CMD_PRECHG && addr[10] |=> bank_open == 4'h0)
    else $error("precharge all left a bank open");
  AST_CLOSE_ONE: assert property (
    run && cmd == sdram_pkg::CMD_PRECHG && !addr[10] |=>
      bank_open == ($past(bank_open) & ~(4'h1 << $past(ba))))
    else $error("single precharge closed the wrong banks");
  AST_CL2: assert property (
    run && cmd == sdram_pkg::CMD_READ && bank_open[ba] && !read_latency_three
      && cke ##1 cke |=> dq_oe)
    else $error("no read data two cycles after read");
  AST_CL3: assert property (
    run && cmd == sdram_pkg::CMD_READ && bank_open[ba] && read_latency_three
      && cke ##1 cke[*2] |=> dq_oe)
    else $error("no read data three cycles after read");
  AST_FREEZE: assert property (
    !cke |-> ##2 $stable({dq_out, dq_oe, bank_open}))
    else $error("outputs moved while clock suspended");
  AST_PD_IN: assert property (
    run && !cke && cmd == sdram_pkg::CMD_NOP && bank_open == 4'h0 && !dq_oe
      |=> power_down)
    else $error("idle clock-enable low did not power down");
  AST_SR_IN: assert property (
    run && !cke && cmd == sdram_pkg::CMD_REFRESH && bank_open == 4'h0
      && !dq_oe |=> self_refresh)
    else $error("refresh with clock-enable low did not self-refresh");
  AST_REFRESH: assert property (
    run && cke && cmd == sdram_pkg::CMD_REFRESH && bank_open == 4'h0 && !dq_oe
      |=> refresh_row == $past(refresh_row) + 12'h001)
    else $error("auto refresh did not step the row");
  AST_WAKE: assert property (
    (power_down || self_refresh) && cke ##1 cke[*2] |=>
      !(power_down || self_refresh))
    else $error("low-power mode not left after clock enable");
  AST_LP_HOLD: assert property (
    $rose(power_down || self_refresh) |=>
      (power_down || self_refresh) [*2])
    else $error("low-power mode left before clock enable returned");
endmodule
bind sdram_command_clock_enable sdram_cce_checker sdram_cce_checker_inst (
  .clk(clk), .resetn(resetn), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
  .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
  .read_latency_three(read_latency_three), .dq_out(dq_out),
  .dq_oe(dq_oe), .bank_open(bank_open), .power_down(power_down),
  .self_refresh(self_refresh), .refresh_row(refresh_row));
`default_nettype wire

/* tb/test_sdram_command_clock_enable.sv */
`default_nettype none
`define CHK(a, e) begin \
  n_checks++; \
  if ((a) !== (e)) begin \
    errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); \
  end \
end
module test_sdram_command_clock_enable;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [2:0] bl;
    logic       il;
    logic       cl3;
    logic [7:0] start;
    int         beats;
  } row_t;
  logic        clk;
  logic        resetn;
  logic        cke;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic [1:0]  ba;
  logic [11:0] addr;
  logic [15:0] dq_in;
  logic [2:0]  burst_len;
  logic        burst_interleave;
  logic        read_latency_three;
  logic [15:0] dq_out;
  logic        dq_oe;
  logic [3:0]  bank_open;
  logic        power_down;
  logic        self_refresh;
  logic [11:0] refresh_row;
  int          errors = 0;
  int          n_checks = 0;
  // Mode settings and start column, beside the beat count they give, or for full page the beats read before the stop
  row_t rows [7] = '{
    '{sdram_pkg::BL_1, 1'b0, 1'b0, 8'h05, 1},
    '{sdram_pkg::BL_2, 1'b0, 1'b1, 8'h03, 2},
    '{sdram_pkg::BL_4, 1'b1, 1'b0, 8'h06, 4},
    '{sdram_pkg::BL_8, 1'b0, 1'b1, 8'h05, 8},
    '{sdram_pkg::BL_8, 1'b1, 1'b0, 8'h03, 8},
    '{sdram_pkg::BL_4, 1'b0, 1'b1, 8'h01, 4},
    '{sdram_pkg::BL_FULL, 1'b0, 1'b0, 8'h00, 4}};
  sdram_command_clock_enable sdram_command_clock_enable_inst (
    .clk(clk), .resetn(resetn), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_in(dq_in),
    .burst_len(burst_len), .burst_interleave(burst_interleave),
    .read_latency_three(read_latency_three), .dq_out(dq_out),
    .dq_oe(dq_oe), .bank_open(bank_open), .power_down(power_down),
    .self_refresh(self_refresh), .refresh_row(refresh_row));
  sdram_ctrl_model sdram_ctrl_model_inst (
    .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .ba(ba), .addr(addr), .dq_in(dq_in), .clk(clk));
  initial clk = 1'b0;
  always #5 clk = ~clk;
  function automatic logic [7:0] col_at(row_t r, int i);
    logic [7:0] m;
    m = (r.bl == sdram_pkg::BL_FULL) ? 8'hFF : 8'((1 << r.bl) - 1);
    return r.il ? r.start ^ 8'(i) : (r.start & ~m) | ((r.start + 8'(i)) & m);
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Full page never ends by itself, so it is cut with a burst stop
  task automatic read_check(input row_t r, input logic [1:0] b,
                            input logic ap);
    int k;
    burst_len = r.bl;
    burst_interleave = r.il;
    read_latency_three = r.cl3;
    sdram_ctrl_model_inst.cmd(sdram_pkg::CMD_READ, b,
                              {1'b0, ap, 2'h0, r.start});
    for (k = 0; k < 8 && dq_oe !== 1'b1; k++) sdram_ctrl_model_inst.idle(1);
    if (k == 8) begin
      errors++;
      tally_and_finish();
    end
    for (int i = 0; i < r.beats; i++) begin
      `CHK({dq_oe, dq_out}, {1'b1, 6'h29, b, col_at(r, i)})
      sdram_ctrl_model_inst.idle(1);
    end
    if (r.bl == sdram_pkg::BL_FULL) begin
      sdram_ctrl_model_inst.cmd(sdram_pkg::CMD_STOP, b, 12'h000);
      sdram_ctrl_model_inst.idle(3);
    end
    `CHK(dq_oe, 1'b0)
  endtask
  initial begin
    resetn = 1'b0;
    burst_len = sdram_pkg::BL_8;
    burst_interleave = 1'b0;
    read_latency_three = 1'b0;
    repeat (16) @(negedge clk);
    `CHK({bank_open, power_down, self_refresh, dq_oe, refresh_row}, 19'h0)
    resetn = 1'b1;
    sdram_ctrl_model_inst.idle(6);
    sdram_ctrl_model_inst.cmd(sdram_pkg::CMD_ROWOPEN, 2'h1, 12'h123);
    sdram_ctrl_model_inst.write8(2'h1);
    sdram_ctrl_model_inst.idle(2);
    foreach (rows[i]) read_check(rows[i], 2'h1, 1'b0);
    read_check(rows[1], 2'h1, 1'b1);
    `CHK(bank_open, 4'h0)
    sdram_ctrl_model_inst.cmd(sdram_pkg::CMD_READ, 2'h1, 12'h000);
    repeat (5) begin
      sdram_ctrl_model_inst.idle(1);
      `CHK(dq_oe, 1'b0)
    end
    for (int b = 0; b < 4; b++)
      sdram_ctrl_model_inst.cmd(sdram_pkg::CMD_ROWOPEN, 2'(b), 12'hFFF);
    sdram_ctrl_model_inst.idle(1);
    `CHK(bank_open, 4'hF)
    sdram_ctrl_model_inst.cmd(sdram_pkg::CMD_PRECHG, 2'h2, 12'h000);
    sdram_ctrl_model_inst.cmd(4'hB, 2'h2, 12'h000);
    sdram_ctrl_model_inst.cmd(sdram_pkg::CMD_REFRESH, 2'h0, 12'h000);
    sdram_ctrl_model_inst.idle(1);
    `CHK({bank_open, refresh_row}, 16'hB000)
    sdram_ctrl_model_inst.cmd(sdram_pkg::CMD_PRECHG, 2'h0, 12'h400);
    sdram_ctrl_model_inst.cmd(sdram_pkg::CMD_REFRESH, 2'h0, 12'h000);
    sdram_ctrl_model_inst.idle(1);
    `CHK({bank_open, refresh_row}, 16'h0001)
    sdram_ctrl_model_inst.set_cke(1'b0);
    sdram_ctrl_model_inst.idle(2);
    `CHK({power_down, self_refresh}, 2'h2)
    sdram_ctrl_model_inst.cmd(sdram_pkg::CMD_ROWOPEN, 2'h0, 12'h000);
    sdram_ctrl_model_inst.idle(1);
    `CHK(bank_open, 4'h0)
    sdram_ctrl_model_inst.set_cke(1'b1);
    sdram_ctrl_model_inst.idle(4);
    `CHK(power_down, 1'b0)
    sdram_ctrl_model_inst.cmd_cke(sdram_pkg::CMD_REFRESH, 1'b0);
    sdram_ctrl_model_inst.idle(2);
    `CHK({self_refresh, power_down, dq_oe}, 3'h4)
    sdram_ctrl_model_inst.set_cke(1'b1);
    sdram_ctrl_model_inst.idle(4);
    `CHK(self_refresh, 1'b0)
    burst_len = sdram_pkg::BL_8;
    burst_interleave = 1'b0;
    read_latency_three = 1'b0;
    sdram_ctrl_model_inst.cmd(sdram_pkg::CMD_ROWOPEN, 2'h1, 12'h123);
    sdram_ctrl_model_inst.cmd(sdram_pkg::CMD_READ, 2'h1, 12'h000);
    sdram_ctrl_model_inst.idle(1);
    // One low edge in mid-burst: the second beat shows twice, frozen
    sdram_ctrl_model_inst.set_cke(1'b0);
    sdram_ctrl_model_inst.set_cke(1'b1);
    for (int j = 0; j < 8; j++) begin
      `CHK({dq_oe, dq_out}, {1'b1, 6'h29, 2'h1, 8'(j | (j == 0))})
      sdram_ctrl_model_inst.idle(1);
    end
    `CHK(dq_oe, 1'b0)
    tally_and_finish();
  end
endmodule
`default_nettype wire
